//--- design/periodic_rtc_timer.sv
// periodic real-time timer: registers, low-frequency tick, interrupt and wake
`timescale 1ns/10ps
`include "rtc_defines.svh"
module periodic_rtc_timer #(
  parameter int DIV_WIDTH = 16
) (
  input  wire logic           clock,             // 10 MHz system clock
  input  wire logic           rst,               // synchronous reset, active high
  input  wire rtc_pkg::addr_t addr,              // register address
  input  wire rtc_pkg::data_t wdata,             // write data
  input  wire logic           wr_en,             // write strobe, one cycle
  input  wire logic           rd_en,             // read strobe, one cycle
  output rtc_pkg::data_t      rdata,             // read data, cycle after rd_en
  input  wire logic           low_freq_clock,    // 32.768 kHz oscillator output pin
  input  wire logic           stop_mode,         // device is in STOP mode
  input  wire logic           standby_mode,      // device is in a non-STOP standby mode
  output logic                periodic_tick_irq, // level interrupt, unmasked status set
  output logic                wake_request,      // return-to-normal request to standby logic
  output logic                low_osc_enable,    // oscillator run enable
  output logic                osc_type_select    // 0 crystal, 1 on-chip RC
);
  import rtc_pkg::*;

  logic          lf_sync;
  logic          lf_prev;
  logic          tick;
  logic          period_event;
  logic          stop_prev;
  logic          stop_exit;
  logic          status_read;
  rtc_control_s  ctrl;
  rtc_control_s  next_ctrl;
  rtc_osc_func_s osc;
  rtc_osc_func_s next_osc;
  logic          status;
  logic          next_status;
  logic          mask;
  logic          next_mask;
  data_t         next_rdata;
  logic          next_irq;
  logic          next_wake;
  logic          next_osc_enable;
  logic          next_osc_type;

  // the oscillator pin is asynchronous to the system clock
  sync2 u_lf_sync (
    .clock (clock),
    .rst   (rst),
    .d     (low_freq_clock),
    .q     (lf_sync)
  );

  // [RQ2] [RQ9] count only rising edges of a running oscillator outside STOP
  assign tick = lf_sync && !lf_prev && osc.low_osc_enable && !stop_mode;

  assign stop_exit   = stop_prev && !stop_mode;
  assign status_read = rd_en && (addr == `RTC_STATUS_OFFSET);

  // [RQ1] [RQ5] divider steered by the control register
  rtc_period_divider #(
    .WIDTH (DIV_WIDTH)
  ) u_divider (
    .clock        (clock),
    .rst          (rst),
    .tick         (tick),
    .run          (ctrl.counter_run_bit),
    .sel          (ctrl.period_select_field),
    .period_event (period_event)
  );

  // register writes; the STOP-exit reload beats a same-cycle write
  always_comb begin
    next_ctrl = ctrl;
    next_osc  = osc;
    next_mask = mask;
    if (wr_en) begin
      if (addr == `RTC_CONTROL_OFFSET) begin
        // [RQ4] [RQ5] [RQ13] control write
        next_ctrl = wdata;
      end else if (addr == `RTC_OSC_FUNC_OFFSET) begin
        next_osc = wdata;
      end else if (addr == `RTC_MASK_OFFSET) begin
        next_mask = wdata[0];
      end
    end
    // [RQ7] oscillator register reinitialised on STOP exit
    if (stop_exit) begin
      next_osc = `RTC_OSC_FUNC_RESET;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (rd_en) begin
      if (addr == `RTC_CONTROL_OFFSET) begin
        next_rdata = ctrl;
      end else if (addr == `RTC_OSC_FUNC_OFFSET) begin
        next_rdata = osc;
      end else if (addr == `RTC_STATUS_OFFSET) begin
        next_rdata = {7'h00, status};
      end else if (addr == `RTC_MASK_OFFSET) begin
        next_rdata = {7'h00, mask};
      end
    end
  end

  // sticky status: a new event in the reading cycle survives the clear
  always_comb begin
    next_status     = (status && !status_read) || period_event;
    // irq built from next values so it tracks status without lag
    next_irq        = next_status && next_mask;
    // [RQ3] wake only from standby, never from STOP
    next_wake       = next_irq && standby_mode && !stop_mode;
    next_osc_enable = next_osc.low_osc_enable;
    next_osc_type   = next_osc.osc_type_select;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // [RQ9] [RQ10] oscillator off, crystal type after reset
      ctrl              <= `RTC_CONTROL_RESET;
      osc               <= `RTC_OSC_FUNC_RESET;
      mask              <= 1'h0;
      status            <= 1'h0;
      rdata             <= 8'h00;
      periodic_tick_irq <= 1'h0;
      wake_request      <= 1'h0;
      low_osc_enable    <= 1'h0;
      osc_type_select   <= 1'h0;
      lf_prev           <= 1'h0;
      stop_prev         <= 1'h0;
    end else begin
      ctrl              <= next_ctrl;
      osc               <= next_osc;
      mask              <= next_mask;
      status            <= next_status;
      rdata             <= next_rdata;
      periodic_tick_irq <= next_irq;
      wake_request      <= next_wake;
      low_osc_enable    <= next_osc_enable;
      osc_type_select   <= next_osc_type;
      lf_prev           <= lf_sync;
      stop_prev         <= stop_mode;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_ctrl_write_03;
    wr_en && addr == `RTC_CONTROL_OFFSET && wdata == 8'h03;
  endsequence

  sequence s_running_quarter;
    ctrl.counter_run_bit && ctrl.period_select_field == 3'h1;
  endsequence

  sequence s_osc_reloaded;
    osc == `RTC_OSC_FUNC_RESET && !low_osc_enable;
  endsequence

  sequence s_status_cleared;
    !status && !periodic_tick_irq;
  endsequence

  a_event_sets_status: assert property (period_event |=> status) // [RQ1]
    else $error("period event lost");

  a_irq_tracks_mask: assert property (periodic_tick_irq == (status && mask)) // [RQ1]
    else $error("irq differs from masked status");

  a_stop_no_count: assert property (stop_mode |-> !period_event) // [RQ2]
    else $error("timer fired in STOP");

  a_wake_from_standby: assert property ( // [RQ3]
    (next_irq && standby_mode && !stop_mode) |=> wake_request)
    else $error("no wake for pending interrupt");

  a_no_wake_in_stop: assert property (stop_mode |=> !wake_request) // [RQ3]
    else $error("wake raised from STOP");

  a_write_03_runs: assert property (s_ctrl_write_03 |=> s_running_quarter) // [RQ13]
    else $error("03h did not run at the 2^13 tap");

  a_run_bit_starts: assert property ( // [RQ5]
    (wr_en && addr == `RTC_CONTROL_OFFSET) |=> ctrl.counter_run_bit == $past(wdata[0]))
    else $error("run bit not taken from write");

  // software may rewrite the register right after the reload, so look one edge only
  a_stop_exit_reload: assert property ( // [RQ7]
    $fell(stop_mode) |=> s_osc_reloaded)
    else $error("oscillator register kept after STOP exit");

  a_osc_off_no_tick: assert property (!osc.low_osc_enable |-> !tick) // [RQ9]
    else $error("tick counted with oscillator stopped");

  a_osc_type_out: assert property ( // [RQ10]
    (wr_en && addr == `RTC_OSC_FUNC_OFFSET && !stop_exit) |=>
      osc_type_select == $past(wdata[1]))
    else $error("type select output not from register");

  a_status_read_clears: assert property ( // [RQ1]
    (status_read && !period_event) |=> s_status_cleared)
    else $error("status read did not clear");

  // sticky status and masked interrupt
  a_status_sticky: assert property ( // [RQ1]
    (status && !status_read) |=> status)
    else $error("status dropped without a read");

  a_status_from_event: assert property ( // [RQ14]
    $rose(status) |-> $past(period_event))
    else $error("status set without a period event");

  // status has no write path, so software cannot fake an event
  a_status_ignores_write: assert property ( // [RQ1]
    (wr_en && addr == `RTC_STATUS_OFFSET && !status && !period_event) |=> !status)
    else $error("write reached the status bit");

  a_masked_irq_low: assert property ( // [RQ1]
    (!mask && !(wr_en && addr == `RTC_MASK_OFFSET)) |=> !periodic_tick_irq)
    else $error("interrupt raised while masked");

  a_irq_follows_event: assert property ( // [RQ1]
    (period_event && next_mask) |=> periodic_tick_irq)
    else $error("unmasked event gave no interrupt");

  a_mask_kept: assert property ( // [RQ1]
    (wr_en && addr == `RTC_MASK_OFFSET) |=> mask == $past(wdata[0]))
    else $error("mask bit not taken from write");

  a_stop_no_status: assert property ( // [RQ2]
    (stop_mode && !status) |=> !status)
    else $error("status set during STOP");

  a_stop_no_tick: assert property ( // [RQ2]
    stop_mode |-> !tick)
    else $error("oscillator edge counted in STOP");

  // wake is only a standby exit path
  a_wake_needs_irq: assert property ( // [RQ3]
    wake_request |-> periodic_tick_irq)
    else $error("wake without a pending interrupt");

  a_awake_no_wake: assert property ( // [RQ3]
    !standby_mode |=> !wake_request)
    else $error("wake raised outside standby");

  // run bit and select field
  a_run_bit_halt: assert property ( // [RQ5]
    !ctrl.counter_run_bit |-> !period_event)
    else $error("event while the run bit is clear");

  a_select_kept: assert property ( // [RQ4]
    (wr_en && addr == `RTC_CONTROL_OFFSET) |=> ctrl.period_select_field == $past(wdata[3:1]))
    else $error("select field not taken from write");

  a_ctrl_stable: assert property ( // [RQ4]
    !(wr_en && addr == `RTC_CONTROL_OFFSET) |=> $stable(ctrl))
    else $error("control register changed without a write");

  // oscillator register and its output copies
  a_osc_stable: assert property ( // [RQ7]
    (!(wr_en && addr == `RTC_OSC_FUNC_OFFSET) && !stop_exit) |=> $stable(osc))
    else $error("oscillator register changed without cause");

  a_osc_enable_copy: assert property ( // [RQ9]
    low_osc_enable == osc.low_osc_enable)
    else $error("enable output differs from register");

  a_osc_type_copy: assert property ( // [RQ10]
    osc_type_select == osc.osc_type_select)
    else $error("type output differs from register");

  a_single_tick: assert property ( // [RQ14]
    tick |=> !tick)
    else $error("one oscillator edge counted twice");

  // read-back of every mapped register; the port shows zero between reads
  a_read_ctrl: assert property ( // [RQ4]
    (rd_en && addr == `RTC_CONTROL_OFFSET) |=> rdata == $past(ctrl))
    else $error("control read-back wrong");

  a_read_osc: assert property ( // [RQ9]
    (rd_en && addr == `RTC_OSC_FUNC_OFFSET) |=> rdata == $past(osc))
    else $error("oscillator read-back wrong");

  a_read_status: assert property ( // [RQ1]
    (rd_en && addr == `RTC_STATUS_OFFSET) |=> rdata == {7'h00, $past(status)})
    else $error("status read-back wrong");

  a_read_mask: assert property ( // [RQ1]
    (rd_en && addr == `RTC_MASK_OFFSET) |=> rdata == {7'h00, $past(mask)})
    else $error("mask read-back wrong");

  a_rdata_idle_zero: assert property ( // [RQ4]
    !rd_en |=> rdata == 8'h00)
    else $error("read data outside a read cycle");

endmodule : periodic_rtc_timer

//--- design/rtc_defines.svh
// constants for the low-frequency periodic real-time timer
// Overview of operation
// [RQ1] Periodic interrupts come from the low-frequency clock, every 1/16 s up to every 2 s.
// [RQ2] The timer counts in every mode with the oscillator running, but never in STOP mode.
// [RQ3] A pending periodic interrupt wakes the device from any standby mode except STOP.
// [RQ4] A three-bit select field in the control register picks one of six periods.
// [RQ5] A run bit in the control register starts the counter when set and halts it when clear.
// [RQ6] Select codes 1x0 give a 2 s period and codes 1x1 give a 1 s period.
// [RQ7] Leaving STOP mode without a reset returns the oscillator register to its reset value.
// [RQ8] Software reprograms the oscillator register after every STOP exit before using the timer.
// [RQ9] The oscillator enable bit stops the oscillator at 0, runs it at 1, and resets to 0.
// [RQ10] The oscillator type bit picks crystal at 0 and on-chip RC at 1, and resets to 0.
// [RQ11] Software waits for the oscillator to settle before it starts the counter.
// [RQ12] Start by writing 01h to the oscillator register, waiting, then 03h to the control one.
// [RQ13] Writing 03h to the control register runs the counter with a 2^13-cycle period.
// [RQ14] The counter is a free binary divider and fires once each time the chosen tap wraps.
// [RQ15] Clearing the run bit holds the divider at zero so a restart begins a full period.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// register offsets on the plain register port
`define RTC_CONTROL_OFFSET    12'h118
`define RTC_OSC_FUNC_OFFSET   12'h119
`define RTC_STATUS_OFFSET     12'h11A
`define RTC_MASK_OFFSET       12'h11B

// reset values
`define RTC_CONTROL_RESET     8'h00
`define RTC_OSC_FUNC_RESET    8'h00
`define RTC_MASK_RESET        8'h00

// divider tap widths (period is 2**tap low-frequency cycles)
`define RTC_TAP_SEL_000       5'h0E
`define RTC_TAP_SEL_001       5'h0D
`define RTC_TAP_SEL_010       5'h0C
`define RTC_TAP_SEL_011       5'h0B
`define RTC_TAP_SEL_1X0       5'h10
`define RTC_TAP_SEL_1X1       5'h0F

// smallest divider that holds the longest tap
`define RTC_MIN_DIV_WIDTH     16

`endif

//--- design/rtc_pkg.sv
// types shared by the periodic real-time timer files
package rtc_pkg;

  typedef logic [11:0] addr_t;
  typedef logic [7:0]  data_t;
  typedef logic [2:0]  period_sel_t;

  // control register layout
  typedef struct packed {
    logic [3:0]  unused;
    period_sel_t period_select_field;
    logic        counter_run_bit;
  } rtc_control_s;

  // oscillator function register layout
  typedef struct packed {
    logic [5:0] unused;
    logic       osc_type_select;
    logic       low_osc_enable;
  } rtc_osc_func_s;

endpackage : rtc_pkg

//--- design/sync2.sv
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module sync2 (
  input  wire logic clock, // system clock
  input  wire logic rst,   // synchronous reset, active high
  input  wire logic d,     // asynchronous level
  output logic      q      // synchronised level
);

  logic meta;
  logic next_meta;
  logic next_q;

  // first flop feeds only the second
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= 1'h0;
      q    <= 1'h0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule : sync2

//--- design/rtc_period_divider.sv
// binary divider of the low-frequency tick with a selectable period tap
`timescale 1ns/10ps
`include "rtc_defines.svh"
module rtc_period_divider #(
  parameter int WIDTH = 16
) (
  input  wire logic                 clock,        // system clock
  input  wire logic                 rst,          // synchronous reset, active high
  input  wire logic                 tick,         // one low-frequency cycle, one-cycle pulse
  input  wire logic                 run,          // counter run level
  input  wire rtc_pkg::period_sel_t sel,          // period select code
  output logic                      period_event  // selected tap wrapped, one-cycle pulse
);
  import rtc_pkg::*;

  generate
    if (WIDTH < `RTC_MIN_DIV_WIDTH) begin : g_width_check
      $error("divider too narrow for the 2 s tap");
    end
  endgenerate

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] tap_mask;
  logic [4:0]       tap;

  // [RQ4] [RQ6] code to tap width
  always_comb begin
    tap = `RTC_TAP_SEL_000;
    case (sel)
      3'h0:    tap = `RTC_TAP_SEL_000;
      3'h1:    tap = `RTC_TAP_SEL_001;
      3'h2:    tap = `RTC_TAP_SEL_010;
      3'h3:    tap = `RTC_TAP_SEL_011;
      3'h4,
      3'h6:    tap = `RTC_TAP_SEL_1X0;
      default: tap = `RTC_TAP_SEL_1X1;
    endcase
    tap_mask = ~({WIDTH{1'h1}} << tap);
  end

  // [RQ14] fire when every bit below the tap is one
  assign period_event = tick && run && ((count & tap_mask) == tap_mask);

  // [RQ15] held at zero while stopped
  always_comb begin
    next_count = count;
    if (!run) begin
      next_count = '0;
    end else if (tick) begin
      next_count = count + 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_run_low_zero: assert property (!run |=> count == '0) // [RQ15]
    else $error("divider not held at zero while stopped");

  a_two_sec_tap: assert property ((period_event && sel[2] && !sel[0]) |-> &count[15:0]) // [RQ6]
    else $error("2 s code fired before sixteen bits wrapped");

  a_one_sec_tap: assert property ((period_event && sel[2] && sel[0]) |-> &count[14:0]) // [RQ6]
    else $error("1 s code fired before fifteen bits wrapped");

  // the tap in force at the event decides, even if a write moves the select then
  a_event_wraps: assert property (period_event |=> (count & $past(tap_mask)) == '0) // [RQ14]
    else $error("tap bits did not wrap after event");

endmodule : rtc_period_divider

//--- bench/rtc_standby_model.sv
// model of the cpu standby logic that sits at the timer's far side
`timescale 1ns/10ps
module rtc_standby_model (
  input  wire logic clock,        // system clock
  input  wire logic rst,          // synchronous reset, active high
  input  wire logic go_standby,   // bench asks for a non-stop standby, one cycle
  input  wire logic go_stop,      // bench holds stop mode while high
  input  wire logic wake_request, // wake request from the timer
  output logic      stop_mode,    // device is in stop
  output logic      standby_mode  // device is in a non-stop standby
);
  logic next_standby_mode;
  logic next_stop_mode;

  // stop ignores wakes, so it is left only by the bench
  always_comb begin
    next_standby_mode = standby_mode;
    next_stop_mode = go_stop;
    if (go_standby) begin
      next_standby_mode = 1'b1;
    end else if (wake_request && !stop_mode) begin
      next_standby_mode = 1'b0;
    end
  end

  // mode levels change only on the system clock, as the real control does
  always_ff @(posedge clock) begin
    if (rst) begin
      standby_mode <= 1'b0;
      stop_mode    <= 1'b0;
    end else begin
      standby_mode <= next_standby_mode;
      stop_mode    <= next_stop_mode;
    end
  end
endmodule : rtc_standby_model

//--- bench/test_low_freq_periodic_rtc_timer.sv
// self-checking bench for the periodic real-time timer
`timescale 1ns/10ps
`include "rtc_defines.svh"
module test_low_freq_periodic_rtc_timer;
  import rtc_pkg::*;
  logic  clock       = 1'b0;
  logic  rst         = 1'b1;
  addr_t addr        = 12'h000;
  data_t wdata       = 8'h00;
  logic  wr_en       = 1'b0;
  logic  rd_en       = 1'b0;
  logic  lfc         = 1'b0;
  logic  lfc_q       = 1'b0;
  logic  go_standby  = 1'b0;
  logic  go_stop     = 1'b0;
  data_t rdata;
  logic  stop_mode, standby_mode, irq, wake, osc_en, osc_type;
  int    ticks       = 0;
  int    cycles      = 0;
  int    miscompares = 0;
  int    compares    = 0;

  periodic_rtc_timer #(.DIV_WIDTH(16)) periodic_rtc_timer_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .low_freq_clock(lfc), .stop_mode(stop_mode),
    .standby_mode(standby_mode), .periodic_tick_irq(irq), .wake_request(wake),
    .low_osc_enable(osc_en), .osc_type_select(osc_type));

  rtc_standby_model rtc_standby_model_i (
    .clock(clock), .rst(rst), .go_standby(go_standby), .go_stop(go_stop),
    .wake_request(wake), .stop_mode(stop_mode), .standby_mode(standby_mode));

  // 10 MHz system clock
  always #50 clock = ~clock;

  // fast oscillator stand-in, eight clocks a cycle, to keep periods short
  always begin
    repeat (4) @(posedge clock);
    lfc <= ~lfc;
  end

  // count oscillator cycles the timer may see, and cut a hang short
  always @(posedge clock) begin
    lfc_q <= lfc;
    cycles <= cycles + 1;
    if (lfc && !lfc_q && osc_en && !stop_mode) ticks <= ticks + 1;
    if (cycles == 80000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  task automatic chk(input string what, input data_t exp, input data_t got);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input addr_t a, input data_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input addr_t a, input data_t exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    chk("rdata", exp, rdata);
  endtask : rd

  task automatic wait_ticks(input int n);
    int t0;
    t0 = ticks;
    while (ticks - t0 < n) @(posedge clock);
  endtask : wait_ticks

  // the interrupt must come one full 2^11 period after the start, give or take sync
  task automatic wait_period(input int t0);
    int k;
    for (k = 0; k < 20000 && irq !== 1'b1; k++) @(posedge clock);
    @(negedge clock);
    chk("irq", 8'h01, {7'h00, irq});
    chk("period", 8'h01, {7'h00, (ticks - t0 >= 2046 && ticks - t0 <= 2050)});
  endtask : wait_period

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    int t0;
    int i;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    rd(`RTC_CONTROL_OFFSET, `RTC_CONTROL_RESET);
    rd(`RTC_OSC_FUNC_OFFSET, `RTC_OSC_FUNC_RESET);
    chk("osc enable", 8'h00, {7'h00, osc_en});
    wr(`RTC_OSC_FUNC_OFFSET, 8'h03);
    rd(`RTC_OSC_FUNC_OFFSET, 8'h03);
    chk("osc enable", 8'h01, {7'h00, osc_en});
    chk("osc type", 8'h01, {7'h00, osc_type});
    // 03h must land as run with the 2^13 code; the loop below stops it again
    wr(`RTC_CONTROL_OFFSET, 8'h03);
    rd(`RTC_CONTROL_OFFSET, 8'h03);
    wr(12'h120, 8'hFF);
    rd(12'h120, 8'h00);
    // every period code is kept as written, run bit left clear
    for (i = 0; i < 8; i++) begin
      wr(`RTC_CONTROL_OFFSET, {4'h0, i[2:0], 1'h0});
      rd(`RTC_CONTROL_OFFSET, {4'h0, i[2:0], 1'h0});
    end
    wr(`RTC_OSC_FUNC_OFFSET, 8'h01);
    repeat (80) @(posedge clock);
    wr(`RTC_MASK_OFFSET, 8'h01);
    t0 = ticks;
    wr(`RTC_CONTROL_OFFSET, 8'h07);
    wait_ticks(1000);
    // stop freezes the count and reloads the oscillator register on exit
    go_stop <= 1'h1;
    repeat (4000) @(posedge clock);
    go_stop <= 1'h0;
    @(negedge clock);
    chk("irq in stop", 8'h00, {7'h00, irq});
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("osc enable", 8'h00, {7'h00, osc_en});
    rd(`RTC_OSC_FUNC_OFFSET, 8'h00);
    wr(`RTC_OSC_FUNC_OFFSET, 8'h01);
    @(posedge clock);
    go_standby <= 1'h1;
    @(posedge clock);
    go_standby <= 1'h0;
    wait_period(t0);
    chk("wake", 8'h01, {7'h00, wake});
    repeat (3) @(negedge clock);
    chk("standby", 8'h00, {7'h00, standby_mode});
    rd(`RTC_STATUS_OFFSET, 8'h01);
    // status is read-only, so this write must not set it again
    wr(`RTC_STATUS_OFFSET, 8'hFF);
    rd(`RTC_STATUS_OFFSET, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wr(`RTC_CONTROL_OFFSET, 8'h06);
    wait_ticks(2100);
    chk("irq halted", 8'h00, {7'h00, irq});
    rd(`RTC_STATUS_OFFSET, 8'h00);
    t0 = ticks;
    wr(`RTC_CONTROL_OFFSET, 8'h07);
    wait_period(t0);
    chk("wake awake", 8'h00, {7'h00, wake});
    wr(`RTC_MASK_OFFSET, 8'h00);
    @(negedge clock);
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(`RTC_STATUS_OFFSET, 8'h01);
    give_verdict();
  end
endmodule : test_low_freq_periodic_rtc_timer
